// File: dilc_cfg.svh
// Offsets, field positions and reset values of the input limit checker
`ifndef DILC_CFG_SVH
`define DILC_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DILC_OFS_CTRL    8'h00
`define DILC_OFS_REF     8'h04
`define DILC_OFS_DIR     8'h08
`define DILC_OFS_SCAN    8'h0C
`define DILC_OFS_CMD     8'h10
`define DILC_OFS_RESULT  8'h14
`define DILC_OFS_STATUS  8'h18
`define DILC_OFS_MASK    8'h1C
`define DILC_OFS_COUNT   8'h20
`define DILC_OFS_BUFDATA 8'h24

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define DILC_CTRL_EN1    0
`define DILC_CTRL_MASK1  1
`define DILC_CTRL_EN2    2
`define DILC_CTRL_MASK2  3
`define DILC_CTRL_RADIX  4

// ----------------------------------------------------------------------
// Status and mask bits, result codes, sizes
// ----------------------------------------------------------------------
`define DILC_STS_DONE    0
`define DILC_STS_FAIL    1
`define DILC_STS_OVFL    2
`define DILC_CODE_PASS   2'h0
`define DILC_CODE_LIM1   2'h1
`define DILC_CODE_LIM2   2'h2
`define DILC_PORTS       4
`define DILC_DEPTH       16
`define DILC_LAST_PORT   2'h3
`define DILC_FULL_COUNT  5'h10
`define DILC_REF_RESET   8'h00

`endif

// File: dilc_pkg.sv
// Types shared by the input limit checker
package dilc_pkg;

   // ----------------------------------------------------------------------
   // Scan sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_SELECT, ST_COMPARE} dilc_state_t;

   // ----------------------------------------------------------------------
   // One reading with its limit verdict
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] port;
      logic [1:0] code;
      logic       below;
      logic       above;
      logic [7:0] value;
   } dilc_entry_t;

   // ----------------------------------------------------------------------
   // Shared limit configuration
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic       en1;
      logic       mask1;
      logic       en2;
      logic       mask2;
      logic [1:0] radix;
      logic [7:0] ref1;
      logic [7:0] ref2;
   } dilc_limits_t;

   // ----------------------------------------------------------------------
   // Whole state of the checker
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [3:0][7:0]         sync1;
      logic [3:0][7:0]         sync2;
      dilc_limits_t            lim;
      logic [3:0]              dir;
      logic [3:0]              scan;
      dilc_state_t             st;
      logic [1:0]              ptr;
      logic [7:0]              sample;
      dilc_entry_t             last;
      logic                    res_valid;
      logic [2:0]              sts;
      logic [2:0]              msk;
      dilc_entry_t [15:0]      rbuf;
      logic [3:0]              wp;
      logic [3:0]              rp;
      logic [4:0]              cnt;
      logic                    pready;
      logic                    pslverr;
      logic [31:0]             prdata;
      logic                    irq;
      logic                    busy;
      logic                    pop_ok;
   } dilc_regs_t;

endpackage : dilc_pkg

// File: dilc_checker.sv
// Digital input limit checker with scan sequencer and APB registers
//
// Contract
// - Compare each 8-bit reading against a reference
// - Exact mode passes only on full equality
// - Mask mode needs ones where reference ones
// - Two limits, each own mode and reference
// - Limits enabled separately; disabled ones never fail
// - Result pass, 1 on first fail, else 2
// - Failure flags below or above versus reference
// - References accept full range 0 to 255
// - One limit setup shared by all ports
// - Only input-direction ports are compared
// - Scan enabling an output port makes it input
// - Scan list holds only the four ports
// - Every visited port appends one buffer reading (code drops it and flags overflow when full with no pop in that cycle)
// - Buffer stores raw value; radix applied on readout (code keeps radix in the control register only; readout returns the raw value)
// - Bit 7 is MSB, bit 0 LSB
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "dilc_cfg.svh"

module dilc_checker (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Digital input lines, port 0 to 3
   input  wire logic [3:0][7:0]   port_in,
   // Port direction, one for input
   output logic      [3:0]        port_dir,
   // Latest verdict
   output logic                   result_valid,
   output dilc_pkg::dilc_entry_t  result,
   output logic                   scan_busy,
   // Interrupt
   output logic                   irq
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   dilc_pkg::dilc_regs_t r;
   dilc_pkg::dilc_regs_t next_r;

   // ----------------------------------------------------------------------
   // Per-port visit qualifier
   // ----------------------------------------------------------------------
   logic [3:0] visit;

   // A listed port is only read while it is set as an input
   generate
      for (genvar p = 0; p < `DILC_PORTS; p++) begin : g_port
         assign visit[p] = r.scan[p] & r.dir[p];
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Limit test of one limit against a value
   // ----------------------------------------------------------------------
   function automatic logic limit_fails(input logic       en,
                                        input logic       mask,
                                        input logic [7:0] value,
                                        input logic [7:0] refv);
      logic pass;
      pass = 1'b1;
      // Mask mode ignores reference zeros
      if (mask) begin
         pass = ((value & refv) == refv);
      end else begin
         pass = (value == refv);
      end
      limit_fails = en & ~pass;
   endfunction : limit_fails

   // ----------------------------------------------------------------------
   // Build the verdict for one sampled reading
   // ----------------------------------------------------------------------
   function automatic dilc_pkg::dilc_entry_t judge(
         input dilc_pkg::dilc_limits_t lim,
         input logic [7:0]             value,
         input logic [1:0]             port);
      dilc_pkg::dilc_entry_t e;
      logic                  f1;
      logic                  f2;
      logic [7:0]            refv;
      e       = '0;
      f1      = limit_fails(lim.en1, lim.mask1, value, lim.ref1);
      f2      = limit_fails(lim.en2, lim.mask2, value, lim.ref2);
      refv    = lim.ref1;
      // Reading keeps the raw value, bit 7 most significant
      e.port  = port;
      e.value = value;
      // First limit wins when both fail
      if (f1) begin
         e.code = `DILC_CODE_LIM1;
         refv   = lim.ref1;
      end else if (f2) begin
         e.code = `DILC_CODE_LIM2;
         refv   = lim.ref2;
      end else begin
         e.code = `DILC_CODE_PASS;
      end
      // Flags compare against the limit that set the code
      if (e.code != `DILC_CODE_PASS) begin
         e.below = (value < refv);
         e.above = (value > refv);
      end else begin
         e.below = 1'b0;
         e.above = 1'b0;
      end
      judge = e;
   endfunction : judge

   // ----------------------------------------------------------------------
   // Bus decode helpers
   // ----------------------------------------------------------------------
   // Decoded strobes of the current cycle
   logic                  setup;
   logic                  access;
   logic                  wr;
   logic                  rd_pop;
   logic                  mapped;
   logic [31:0]           rd_word;
   logic                  start;
   logic [2:0]            w1c;
   logic [2:0]            events;
   logic                  push;
   dilc_pkg::dilc_entry_t verdict;

   // Phase and address decode
   always_comb begin
      setup  = psel & ~penable;
      access = psel & penable & r.pready;
      wr     = access & pwrite & ~r.pslverr;
      // Pop only a reading that the setup cycle has shown
      rd_pop = access & ~pwrite & (paddr == `DILC_OFS_BUFDATA) & r.pop_ok;
      // Ten word offsets answer; anything else errors
      case (paddr)
         `DILC_OFS_CTRL,
         `DILC_OFS_REF,
         `DILC_OFS_DIR,
         `DILC_OFS_SCAN,
         `DILC_OFS_CMD,
         `DILC_OFS_RESULT,
         `DILC_OFS_STATUS,
         `DILC_OFS_MASK,
         `DILC_OFS_COUNT,
         `DILC_OFS_BUFDATA: mapped = 1'b1;
         default:           mapped = 1'b0;
      endcase
   end

   // Read data selection, sampled in the setup cycle
   always_comb begin
      rd_word = 32'h0000_0000;
      // Narrow fields sit in the low bits, the rest reads zero
      case (paddr)
         `DILC_OFS_CTRL: begin
            rd_word[`DILC_CTRL_EN1]   = r.lim.en1;
            rd_word[`DILC_CTRL_MASK1] = r.lim.mask1;
            rd_word[`DILC_CTRL_EN2]   = r.lim.en2;
            rd_word[`DILC_CTRL_MASK2] = r.lim.mask2;
            rd_word[`DILC_CTRL_RADIX +: 2] = r.lim.radix;
         end
         `DILC_OFS_REF:    rd_word[15:0] = {r.lim.ref2, r.lim.ref1};
         `DILC_OFS_DIR:    rd_word[3:0]  = r.dir;
         `DILC_OFS_SCAN:   rd_word[3:0]  = r.scan;
         `DILC_OFS_CMD:    rd_word[0]    = r.busy;
         `DILC_OFS_RESULT: rd_word[13:0] = r.last;
         `DILC_OFS_STATUS: rd_word[2:0]  = r.sts;
         `DILC_OFS_MASK:   rd_word[2:0]  = r.msk;
         `DILC_OFS_COUNT:  rd_word[4:0]  = r.cnt;
         // Empty buffer reads as zero
         `DILC_OFS_BUFDATA: begin
            if (r.cnt != 5'h00) begin
               rd_word[13:0] = r.rbuf[r.rp];
            end
         end
         default:          rd_word = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      // Defaults: pulses and strobes drop unless set below
      next_r           = r;
      start            = 1'b0;
      w1c              = 3'h0;
      events           = 3'h0;
      push             = 1'b0;
      verdict          = judge(r.lim, r.sample, r.ptr);
      next_r.res_valid = 1'b0;

      // Two-stage synchronisers on the input lines
      // Lines are asynchronous; only the second stage feeds logic
      next_r.sync1 = port_in;
      next_r.sync2 = r.sync1;

      // APB answer: ready one cycle after setup, no wait states
      // Read word is captured at setup and stands through access
      next_r.pready  = setup;
      next_r.pslverr = setup & ~mapped;
      if (setup) begin
         next_r.prdata = rd_word;
      end
      // A push racing an empty read must not be popped unseen
      next_r.pop_ok = setup & (paddr == `DILC_OFS_BUFDATA) & (r.cnt != 5'h00);

      // Register writes
      if (wr) begin
         case (paddr)
            `DILC_OFS_CTRL: begin
               next_r.lim.en1   = pwdata[`DILC_CTRL_EN1];
               next_r.lim.mask1 = pwdata[`DILC_CTRL_MASK1];
               next_r.lim.en2   = pwdata[`DILC_CTRL_EN2];
               next_r.lim.mask2 = pwdata[`DILC_CTRL_MASK2];
               next_r.lim.radix = pwdata[`DILC_CTRL_RADIX +: 2];
            end
            // Both references take the full byte range
            `DILC_OFS_REF: begin
               next_r.lim.ref1 = pwdata[7:0];
               next_r.lim.ref2 = pwdata[15:8];
            end
            `DILC_OFS_DIR:  next_r.dir = pwdata[3:0];
            // Writing the scan list also turns its ports to inputs
            `DILC_OFS_SCAN: begin
               next_r.scan = pwdata[3:0];
               next_r.dir  = r.dir | pwdata[3:0];
            end
            // Start is a strobe; it is ignored while a pass runs
            `DILC_OFS_CMD:    start = pwdata[0];
            `DILC_OFS_STATUS: w1c   = pwdata[2:0];
            `DILC_OFS_MASK:   next_r.msk = pwdata[2:0];
            default: ;
         endcase
      end

      // Scan sequencer
      case (r.st)
         dilc_pkg::ST_IDLE: begin
            if (start) begin
               next_r.ptr = 2'h0;
               next_r.st  = dilc_pkg::ST_SELECT;
            end
         end
         // Skipped ports cost one cycle each
         dilc_pkg::ST_SELECT: begin
            if (visit[r.ptr]) begin
               next_r.sample = r.sync2[r.ptr];
               next_r.st     = dilc_pkg::ST_COMPARE;
            end else if (r.ptr == `DILC_LAST_PORT) begin
               next_r.st = dilc_pkg::ST_IDLE;
               events[`DILC_STS_DONE] = 1'b1;
            end else begin
               next_r.ptr = r.ptr + 2'h1;
            end
         end
         dilc_pkg::ST_COMPARE: begin
            // Verdict leaves one clock after the value was sampled
            next_r.last      = verdict;
            next_r.res_valid = 1'b1;
            push             = 1'b1;
            if (verdict.code != `DILC_CODE_PASS) begin
               events[`DILC_STS_FAIL] = 1'b1;
            end
            if (r.ptr == `DILC_LAST_PORT) begin
               next_r.st = dilc_pkg::ST_IDLE;
               events[`DILC_STS_DONE] = 1'b1;
            end else begin
               next_r.ptr = r.ptr + 2'h1;
               next_r.st  = dilc_pkg::ST_SELECT;
            end
         end
         default: next_r.st = dilc_pkg::ST_IDLE;
      endcase

      // Busy kept in a flop so the pin comes from a register
      next_r.busy = (next_r.st != dilc_pkg::ST_IDLE);

      // Reading buffer: pop on data read, push on verdict
      if (rd_pop && r.cnt != 5'h00) begin
         next_r.rp  = r.rp + 4'h1;
         next_r.cnt = next_r.cnt - 5'h01;
      end
      // A full buffer with no pop in the same cycle drops the reading and flags overflow
      if (push) begin
         if (r.cnt == `DILC_FULL_COUNT && !(rd_pop)) begin
            events[`DILC_STS_OVFL] = 1'b1;
         end else begin
            next_r.rbuf[r.wp] = verdict;
            next_r.wp         = r.wp + 4'h1;
            next_r.cnt        = next_r.cnt + 5'h01;
         end
      end

      // Sticky status: a new event wins over a clear
      next_r.sts = (r.sts & ~w1c) | events;
      // Interrupt follows the next status so it never lags a clear
      next_r.irq = |(next_r.sts & next_r.msk);
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   // Asynchronous reset loads constants only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r          <= '0;
         r.st       <= dilc_pkg::ST_IDLE;
         // Limits start disabled with cleared references
         r.lim.ref1 <= `DILC_REF_RESET;
         r.lim.ref2 <= `DILC_REF_RESET;
         r.lim.en1  <= 1'b0;
         r.lim.en2  <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------------------------------------
   assign prdata       = r.prdata;
   assign pready       = r.pready;
   assign pslverr      = r.pslverr;
   assign port_dir     = r.dir;
   assign result_valid = r.res_valid;
   assign result       = r.last;
   assign scan_busy    = r.busy;
   assign irq          = r.irq;

endmodule : dilc_checker

// File: dilc_chk.sv
// Concurrent checks on the ports of the input limit checker
`timescale 1ns/100ps
`include "dilc_cfg.svh"

module dilc_chk (
   // Clock, reset and bus
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [7:0]            paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   // Lines, verdict and interrupt
   input wire logic [3:0][7:0]       port_in,
   input wire logic [3:0]            port_dir,
   input wire logic                  result_valid,
   input wire dilc_pkg::dilc_entry_t result,
   input wire logic                  scan_busy,
   input wire logic                  irq
);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Scan bits of the word being written
   logic [3:0] scan_w;
   assign scan_w = pwdata[3:0];

   setup_ready_a: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without pready");
   code_legal_a: assert property (result_valid |-> result.code != 2'h3)
      else $error("illegal result code");
   pass_clear_a: assert property (result_valid && result.code == 2'h0
      |-> !result.below && !result.above) else $error("flag on pass");
   fail_flag_a: assert property (result_valid && result.code != 2'h0
      |-> result.below ^ result.above) else $error("bad fail flags");
   hold_result_a: assert property ($changed(result) |-> result_valid)
      else $error("result moved without verdict");
   input_only_a: assert property (result_valid |-> port_dir[result.port])
      else $error("verdict on output port");
   scan_dir_a: assert property (psel && penable && pready && pwrite
      && paddr == `DILC_OFS_SCAN |=> (port_dir & $past(scan_w)) == $past(scan_w))
      else $error("scan did not set input direction");
   scan_bound_a: assert property ($rose(scan_busy) |-> ##[1:12] !scan_busy)
      else $error("scan pass too long");

   // Main scenarios reached
   cover property (result_valid && result.code == 2'h1);
   cover property (result_valid && result.code == 2'h2);
   cover property (pslverr);
   cover property ($rose(irq));
endmodule : dilc_chk

bind dilc_checker dilc_chk dilc_chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .port_in(port_in), .port_dir(port_dir), .result_valid(result_valid),
   .result(result), .scan_busy(scan_busy), .irq(irq));

// File: dilc_lines.sv
// Model of the external input lines feeding the four ports
`timescale 1ns/100ps

module dilc_lines (
   // Clock, reset and levels to present
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic [3:0][7:0] pat,
   // Lines into the checker
   output logic      [3:0][7:0] port_in
);
   // Lines take a new level just after a clock edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) port_in <= '0;
      else port_in <= pat;
   end
endmodule : dilc_lines

// File: dilc_checker_tb.sv
// Self-checking bench of the input limit checker
`timescale 1ns/100ps
`include "dilc_cfg.svh"

module dilc_checker_tb;
   logic                  pclk, presetn, psel, penable, pwrite, last_err;
   logic [7:0]            paddr;
   logic [31:0]           pwdata, prdata, r, exp_v;
   logic                  pready, pslverr, result_valid, scan_busy, irq;
   logic [3:0]            port_dir;
   logic [3:0][7:0]       pat, port_in;
   dilc_pkg::dilc_entry_t result;
   int                    n_fail, check_count;
   logic [13:0]           seen_res;
   int                    n_valid = 0;
   // Rows: control, references, input, expected {code, below, above}
   logic [35:0] tbl [9] = '{36'h31_000F_0F_0, 36'h01_000F_0E_6,
      36'h03_000F_0E_6, 36'h03_000F_AF_0, 36'h05_00FF_FF_9,
      36'h05_0F0F_00_6, 36'h00_0F0F_24_0, 36'h01_000F_24_5,
      36'h0D_F00F_0F_A};

   dilc_checker dilc_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_in(port_in), .port_dir(port_dir), .result_valid(result_valid),
      .result(result), .scan_busy(scan_busy), .irq(irq));
   dilc_lines dilc_lines_i (.pclk(pclk), .presetn(presetn), .pat(pat),
      .port_in(port_in));

   // Catch every verdict pulse on the result pins
   always @(posedge pclk) begin
      if (result_valid === 1'b1) begin
         seen_res <= result;
         n_valid++;
      end
   end

   // ----------------------------------------------------------------
   // Bus cycles, comparison and verdict
   // ----------------------------------------------------------------
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : bus

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   // Free-running clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // Hang guard
   initial begin
      #100000;
      n_fail++;
      report_and_stop();
   end

   // Test sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pat} = '0;
      n_fail = 0;
      check_count = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 3; i++) begin
         bus(1'b0, 8'(4 * i), 32'h0);
         chk("reset value", r, 32'h0);
      end
      chk("reset dir", 32'(port_dir), 32'h0);
      $display("reset test done");
      for (int i = 0; i < 9; i++) begin
         pat <= {4{tbl[i][11:4]}};
         bus(1'b1, `DILC_OFS_CTRL, 32'(tbl[i][35:28]));
         bus(1'b1, `DILC_OFS_REF, 32'(tbl[i][27:12]));
         bus(1'b1, `DILC_OFS_SCAN, 32'h2);
         bus(1'b1, `DILC_OFS_CMD, 32'h1);
         @(posedge pclk);
         repeat (20) if (scan_busy === 1'b1) @(posedge pclk);
         exp_v = {18'h0, 2'h1, tbl[i][3:0], tbl[i][11:4]};
         bus(1'b0, `DILC_OFS_RESULT, 32'h0);
         chk("verdict", r, exp_v);
         chk("result pins", 32'(seen_res), exp_v);
         chk("dir", 32'(port_dir), 32'h2);
      end
      $display("limit test done");
      bus(1'b0, `DILC_OFS_COUNT, 32'h0);
      chk("count", r, 32'h9);
      chk("verdict pulses", 32'(n_valid), 32'h9);
      bus(1'b1, `DILC_OFS_CTRL, 32'h20);
      bus(1'b0, `DILC_OFS_BUFDATA, 32'h0);
      chk("first entry", r, 32'h100F);
      bus(1'b1, `DILC_OFS_SCAN, 32'hFF);
      bus(1'b0, `DILC_OFS_SCAN, 32'h0);
      chk("scan list", r, 32'hF);
      bus(1'b1, `DILC_OFS_DIR, 32'h0);
      bus(1'b1, `DILC_OFS_CMD, 32'h1);
      repeat (20) if (scan_busy === 1'b1) @(posedge pclk);
      bus(1'b0, `DILC_OFS_COUNT, 32'h0);
      chk("count after skip", r, 32'h8);
      chk("no output verdict", 32'(n_valid), 32'h9);
      bus(1'b0, 8'h40, 32'h0);
      chk("unmapped data", r, 32'h0);
      chk("unmapped err", 32'(last_err), 32'h1);
      $display("buffer test done");
      bus(1'b1, `DILC_OFS_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      chk("irq masked", 32'(irq), 32'h0);
      bus(1'b1, `DILC_OFS_MASK, 32'h3);
      repeat (2) @(posedge pclk);
      chk("irq raised", 32'(irq), 32'h1);
      bus(1'b0, `DILC_OFS_STATUS, 32'h0);
      chk("status", r, 32'h3);
      bus(1'b1, `DILC_OFS_STATUS, 32'h3);
      repeat (2) @(posedge pclk);
      chk("irq cleared", 32'(irq), 32'h0);
      $display("interrupt test done");
      report_and_stop();
   end
endmodule : dilc_checker_tb
